// ### hdl/clock_ctrl_pkg.sv
// Shared constants and types for the clock mode and CPU clock select logic
package clock_ctrl_pkg;

  // ****************************************************************
  // Register addresses and reset values
  // ****************************************************************
  localparam logic [15:0] ADDR_PIN_MODE  = 16'hFF9F;
  localparam logic [15:0] ADDR_CPU_CLK   = 16'hFFFB;
  localparam logic [7:0]  PIN_MODE_RESET = 8'h00;
  localparam logic [7:0]  CPU_CLK_RESET  = 8'h01;

  // ****************************************************************
  // Field positions and writable masks
  // ****************************************************************
  localparam int          PIN_GAIN_BIT    = 0;
  localparam int          PIN_SUB_SEL_BIT = 4;
  localparam int          PIN_SUB_EXT_BIT = 5;
  localparam int          PIN_HS_SEL_BIT  = 6;
  localparam int          PIN_HS_EXT_BIT  = 7;
  localparam logic [7:0]  PIN_WR_MASK     = 8'hF1;
  localparam int          CPU_DIV_LSB     = 0;
  localparam int          CPU_CSS_BIT     = 4;
  localparam int          CPU_CLS_BIT     = 5;
  localparam int          CPU_XT_BIT      = 6;
  localparam logic [7:0]  CPU_WR_MASK     = 8'h57;
  localparam logic [2:0]  CPU_DIV_MAX     = 3'h4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          WITHHOLD_MIN_NS = 4060;
  localparam int          WITHHOLD_CYCLES = (WITHHOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          EXT_HOLD_EDGES  = 160;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {PIN_PORT, PIN_CRYSTAL, PIN_EXTCLK} pin_mode_e;
  typedef enum logic [1:0] {HOLD_IDLE, HOLD_TIME, HOLD_EXT, HOLD_STAB} hold_state_e;

endpackage

// ### hdl/sync_edge.sv
// Two-stage synchroniser with rising edge detect for a pin-level clock
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pinIn,
  output logic      riseEdge
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic edgeSeen;
    logic [1:0] warm;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // ****************************************************************
  // Next state: first stage feeds only the second
  // ****************************************************************
  always_comb begin
    s_d          = s_q;
    s_d.s1       = pinIn;
    s_d.s2       = s_q.s1;
    s_d.s3       = s_q.s2;
    // A pin held high through reset must not look like a rising edge
    s_d.warm     = (s_q.warm == 2'h3) ? 2'h3 : s_q.warm + 2'h1;
    s_d.edgeSeen = s_q.s2 & ~s_q.s3 & (s_q.warm == 2'h3);
  end

  // Register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign riseEdge = s_q.edgeSeen;

endmodule
`default_nettype wire

// ### hdl/cpu_clock_divider.sv
// CPU clock enable generator with switch-at-period-end source selection
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_divider
  import clock_ctrl_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       hold,
  input  wire logic       reqCss,
  input  wire logic [2:0] reqDiv,
  input  wire logic       subEdge,
  output logic            cpuClkEn,
  output logic            instrEn,
  output logic            cpuOnSub
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       subPh;
    logic       curCss;
    logic [2:0] curDiv;
    logic       en;
    logic       instrPh;
    logic       instrEn;
  } div_s;

  div_s s_q;
  div_s s_d;

  // Terminal count for main clock divided by 2^div
  function automatic logic [3:0] divLast(input logic [2:0] div);
    case (div)
      3'h0:    divLast = 4'h0;
      3'h1:    divLast = 4'h1;
      3'h2:    divLast = 4'h3;
      3'h3:    divLast = 4'h7;
      default: divLast = 4'hF;
    endcase
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d         = s_q;
    s_d.en      = 1'b0;
    s_d.instrEn = 1'b0;
    if (hold) begin
      // No pulses while held, so a new selection cannot cut one short
      s_d.cnt    = 4'h0;
      s_d.subPh  = 1'b0;
      s_d.curCss = reqCss;
      s_d.curDiv = reqDiv;
    end else if (s_q.curCss) begin
      if (subEdge) begin
        s_d.subPh = ~s_q.subPh;
        s_d.en    = s_q.subPh;
      end
    end else if (s_q.cnt == divLast(s_q.curDiv)) begin
      s_d.en  = 1'b1;
      s_d.cnt = 4'h0;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
    // adopt new source at a period boundary, or at once while held
    if (s_d.en) begin
      s_d.curCss  = reqCss;
      s_d.curDiv  = reqDiv;
      s_d.cnt     = 4'h0;
      s_d.subPh   = 1'b0;
      s_d.instrPh = ~s_q.instrPh;
      // one instruction slot per two CPU clocks
      s_d.instrEn = s_q.instrPh;
    end
  end

  // Register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q        <= '0;
      s_q.curDiv <= CPU_CLK_RESET[2:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign cpuClkEn = s_q.en;
  assign instrEn  = s_q.instrEn;
  assign cpuOnSub = s_q.curCss;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_SWITCH_AT_EDGE: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!$past(hold) && ($changed(s_q.curDiv) || $changed(s_q.curCss))) |-> s_q.en)
    else $error("CPU clock selection changed inside a period");

  // Main clock halved: one idle cycle, then the next pulse unless held
  sequence halfPeriod;
    ##1 !s_q.en ##1 (s_q.en || $past(hold));
  endsequence

  AST_INSTR_TWO_CLOCKS: assert property (
    @(posedge clk_sys) disable iff (srst)
    s_q.instrEn |-> s_q.en && !$past(s_q.instrEn))
    else $error("Instruction slot not aligned to a CPU clock pulse");

  AST_MAIN_DIV_RATE: assert property (
    @(posedge clk_sys) disable iff (srst)
    (s_q.en && !s_q.curCss && s_q.curDiv == 3'h1 && !hold && $stable(reqDiv)
     && !reqCss) |-> halfPeriod)
    else $error("Main clock divided by two has wrong rate");

endmodule
`default_nettype wire

// ### hdl/clock_mode_cpu_clock.sv
// Clock pin mode register, CPU clock control register and CPU clock withholding
`timescale 1ns/1ps
`default_nettype none

module clock_mode_cpu_clock
  import clock_ctrl_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [15:0] busAddr,
  input  wire logic       busWr,
  input  wire logic       busBitOp,
  input  wire logic [2:0] busBitSel,
  input  wire logic [7:0] busWrData,
  input  wire logic       busRd,
  output logic [7:0]      busRdData,
  input  wire logic       hsOscStop,
  input  wire logic       mainClkIsHs,
  input  wire logic       stopRelease,
  input  wire logic       oscStableDone,
  input  wire logic       hsExtClkPin,
  input  wire logic       subClkPin,
  output var pin_mode_e   hsPinMode,
  output var pin_mode_e   subPinMode,
  output logic            hsCrystalEnable,
  output logic            hsExtClockEnable,
  output logic            subCrystalEnable,
  output logic            subExtClockEnable,
  output logic            gainHigh,
  output logic            cpuHold,
  output logic            cpuClkEn,
  output logic            instrEn,
  output logic            cpuOnSubclock
);

  typedef struct packed {
    logic [7:0]  pinReg;
    logic [7:0]  cpuReg;
    logic        gainLocked;
    hold_state_e holdState;
    logic [8:0]  holdCnt;
    logic [7:0]  rdData;
    pin_mode_e   hsMode;
    pin_mode_e   subMode;
    logic        hsXtalEn;
    logic        hsExtEn;
    logic        subXtalEn;
    logic        subExtEn;
    logic        hold;
  } ctrl_s;

  ctrl_s s_q;
  ctrl_s s_d;

  logic extEdge;
  logic subEdge;
  logic cpuOnSub;
  logic [7:0] mergedWr;
  logic       wrPin;
  logic       wrCpu;
  logic       badSel;

  // Byte write or single-bit write of the addressed register
  function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] data,
                                           input logic bitOp, input logic [2:0] sel);
    logic [7:0] res;
    res = old;
    if (bitOp) begin
      res[sel] = data[0];
    end else begin
      res = data;
    end
    return res;
  endfunction

  // Two-bit pin mode decode shared by both clock pin pairs
  function automatic pin_mode_e decodeMode(input logic extBit, input logic selBit);
    if (!selBit) begin
      decodeMode = PIN_PORT;
    end else if (extBit) begin
      decodeMode = PIN_EXTCLK;
    end else begin
      decodeMode = PIN_CRYSTAL;
    end
  endfunction

  // ****************************************************************
  // Pin clocks and CPU clock generation
  // ****************************************************************
  sync_edge u_ext_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .pinIn    (hsExtClkPin),
    .riseEdge (extEdge)
  );

  sync_edge u_sub_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .pinIn    (subClkPin),
    .riseEdge (subEdge)
  );

  cpu_clock_divider u_divider (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .hold     (s_q.hold),
    .reqCss   (s_q.cpuReg[CPU_CSS_BIT]),
    .reqDiv   (s_q.cpuReg[CPU_DIV_LSB +: 3]),
    .subEdge  (subEdge),
    .cpuClkEn (cpuClkEn),
    .instrEn  (instrEn),
    .cpuOnSub (cpuOnSub)
  );

  // write decode, byte or bit form
  assign wrPin    = busWr && (busAddr == ADDR_PIN_MODE);
  assign wrCpu    = busWr && (busAddr == ADDR_CPU_CLK);
  assign mergedWr = mergeByte(wrPin ? s_q.pinReg : s_q.cpuReg, busWrData, busBitOp, busBitSel);
  // divider codes above 4 are prohibited
  assign badSel   = mergedWr[CPU_DIV_LSB +: 3] > CPU_DIV_MAX;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // Pin mode register; unused bits never stored
    if (wrPin) begin
      s_d.pinReg = mergedWr & PIN_WR_MASK;
      // gain frozen after its first change
      if (s_q.gainLocked) begin
        s_d.pinReg[PIN_GAIN_BIT] = s_q.pinReg[PIN_GAIN_BIT];
      end else if (mergedWr[PIN_GAIN_BIT] != s_q.pinReg[PIN_GAIN_BIT]) begin
        s_d.gainLocked = 1'b1;
      end
    end
    // status bit and bits 3, 7 are not stored
    if (wrCpu) begin
      s_d.cpuReg[CPU_XT_BIT] = mergedWr[CPU_XT_BIT];
      // keep last valid source and divider
      if (!badSel) begin
        s_d.cpuReg[CPU_CSS_BIT]     = mergedWr[CPU_CSS_BIT];
        s_d.cpuReg[CPU_DIV_LSB +: 3] = mergedWr[CPU_DIV_LSB +: 3];
      end
    end

    // Withhold sequencer
    case (s_q.holdState)
      HOLD_IDLE: begin
        // gain rising while CPU runs from the high-speed clock
        if (!s_q.pinReg[PIN_GAIN_BIT] && s_d.pinReg[PIN_GAIN_BIT] && mainClkIsHs
            && !cpuOnSub && s_q.hsMode == PIN_CRYSTAL) begin
          s_d.holdState = HOLD_TIME;
          s_d.holdCnt   = 9'(WITHHOLD_CYCLES - 1);
        end else if (!s_q.pinReg[PIN_GAIN_BIT] && s_d.pinReg[PIN_GAIN_BIT]
                     && mainClkIsHs && !cpuOnSub && s_q.hsMode == PIN_EXTCLK) begin
          s_d.holdState = HOLD_EXT;
          s_d.holdCnt   = 9'(EXT_HOLD_EDGES);
        // stop release, action depends on the main clock source
        end else if (stopRelease && s_q.pinReg[PIN_GAIN_BIT]) begin
          if (!mainClkIsHs) begin
            s_d.holdState = HOLD_TIME;
            s_d.holdCnt   = 9'(WITHHOLD_CYCLES - 1);
          end else if (s_q.hsMode == PIN_EXTCLK) begin
            s_d.holdState = HOLD_EXT;
            s_d.holdCnt   = 9'(EXT_HOLD_EDGES);
          end else begin
            s_d.holdState = HOLD_STAB;
          end
        end
      end
      HOLD_TIME: begin
        if (s_q.holdCnt == 9'h000) begin
          s_d.holdState = HOLD_IDLE;
        end else begin
          s_d.holdCnt = s_q.holdCnt - 9'h001;
        end
      end
      HOLD_EXT: begin
        // Counts edges of the external clock, not system cycles
        if (extEdge) begin
          s_d.holdCnt = s_q.holdCnt - 9'h001;
          if (s_q.holdCnt == 9'h001) begin
            s_d.holdState = HOLD_IDLE;
          end
        end
      end
      HOLD_STAB: begin
        if (oscStableDone) begin
          s_d.holdState = HOLD_IDLE;
        end
      end
      default: begin
        s_d.holdState = HOLD_IDLE;
      end
    endcase
    s_d.hold = (s_d.holdState != HOLD_IDLE);

    s_d.hsMode  = decodeMode(s_d.pinReg[PIN_HS_EXT_BIT], s_d.pinReg[PIN_HS_SEL_BIT]);
    s_d.subMode = s_d.cpuReg[CPU_XT_BIT] ? PIN_CRYSTAL :
                  decodeMode(s_d.pinReg[PIN_SUB_EXT_BIT], s_d.pinReg[PIN_SUB_SEL_BIT]);
    // stop bit gates whichever high-speed source the mode selects
    s_d.hsXtalEn  = (s_d.hsMode == PIN_CRYSTAL) && !hsOscStop;
    s_d.hsExtEn   = (s_d.hsMode == PIN_EXTCLK) && !hsOscStop;
    s_d.subXtalEn = (s_d.subMode == PIN_CRYSTAL);
    s_d.subExtEn  = (s_d.subMode == PIN_EXTCLK);

    // Read port; unmapped addresses read zero
    s_d.rdData = 8'h00;
    if (busRd && busAddr == ADDR_PIN_MODE) begin
      s_d.rdData = s_q.pinReg;
    end else if (busRd && busAddr == ADDR_CPU_CLK) begin
      s_d.rdData              = s_q.cpuReg;
      s_d.rdData[CPU_CLS_BIT] = cpuOnSub;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q        <= '0;
      s_q.pinReg <= PIN_MODE_RESET;
      s_q.cpuReg <= CPU_CLK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign busRdData         = s_q.rdData;
  assign hsPinMode         = s_q.hsMode;
  assign subPinMode        = s_q.subMode;
  assign hsCrystalEnable   = s_q.hsXtalEn;
  assign hsExtClockEnable  = s_q.hsExtEn;
  assign subCrystalEnable  = s_q.subXtalEn;
  assign subExtClockEnable = s_q.subExtEn;
  assign gainHigh          = s_q.pinReg[PIN_GAIN_BIT];
  assign cpuHold           = s_q.hold;
  assign cpuOnSubclock     = cpuOnSub;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper: length of each timed hold and edges seen in an external hold
  logic [9:0] timedLen;
  logic [8:0] edgeSeen;
  always_ff @(posedge clk_sys) begin
    if (srst || s_q.holdState == HOLD_IDLE) begin
      timedLen <= 10'h000;
      edgeSeen <= 9'h000;
    end else begin
      timedLen <= timedLen + 10'h001;
      edgeSeen <= edgeSeen + {8'h00, extEdge};
    end
  end

  AST_PIN_RESET: assert property (
    @(posedge clk_sys) srst |=> s_q.pinReg == 8'h00 && s_q.hsMode == PIN_PORT && !gainHigh)
    else $error("Pin mode register not cleared by reset");

  AST_CPU_RESET: assert property (
    @(posedge clk_sys) srst |=> s_q.cpuReg == 8'h01)
    else $error("CPU clock control not 01 after reset");

  AST_GAIN_LOCK: assert property (
    @(posedge clk_sys) disable iff (srst)
    s_q.gainLocked |=> $stable(gainHigh) && s_q.gainLocked)
    else $error("Gain changed after first change");

  AST_HS_DECODE: assert property (
    @(posedge clk_sys) disable iff (srst)
    ##1 (hsPinMode == PIN_EXTCLK) == (s_q.pinReg[7:6] == 2'b11)
        && (hsPinMode == PIN_CRYSTAL) == (s_q.pinReg[7:6] == 2'b01))
    else $error("High-speed pin mode decode wrong");

  AST_BIT_WRITE: assert property (
    @(posedge clk_sys) disable iff (srst)
    (wrPin && busBitOp && busBitSel == 3'h7) |=>
      s_q.pinReg[6:0] == $past(s_q.pinReg[6:0]) && s_q.pinReg[7] == $past(busWrData[0]))
    else $error("Single-bit write disturbed other bits");

  AST_CLS_READ: assert property (
    @(posedge clk_sys) disable iff (srst)
    (busRd && busAddr == ADDR_CPU_CLK) |=> busRdData[5] == $past(cpuOnSub))
    else $error("Clock status bit does not track CPU source");

  AST_BAD_SEL: assert property (
    @(posedge clk_sys) disable iff (srst)
    (wrCpu && badSel) |=> $stable(s_q.cpuReg[4:0]))
    else $error("Prohibited selection was stored");

  AST_TIMED_LEN: assert property (
    @(posedge clk_sys) disable iff (srst)
    $fell(s_q.holdState == HOLD_TIME) |-> $past(timedLen) == 10'(WITHHOLD_CYCLES - 1))
    else $error("Timed withhold length wrong");

  AST_EXT_EDGES: assert property (
    @(posedge clk_sys) disable iff (srst)
    $fell(s_q.holdState == HOLD_EXT) |-> $past(edgeSeen) == 9'(EXT_HOLD_EDGES - 1))
    else $error("External withhold edge count wrong");

  sequence stabWait;
    s_q.holdState == HOLD_STAB && !oscStableDone;
  endsequence

  AST_STAB_HOLD: assert property (
    @(posedge clk_sys) disable iff (srst)
    stabWait |=> s_q.holdState == HOLD_STAB && cpuHold)
    else $error("Stabilization hold left early");

  AST_STOP_GATE: assert property (
    @(posedge clk_sys) disable iff (srst)
    hsOscStop |=> !hsCrystalEnable && !hsExtClockEnable)
    else $error("High-speed clock runs while stopped");

endmodule
`default_nettype wire

// ### verification/test_clock_mode_and_cpu_clock_select.sv
// Self-checking testbench for the clock pin mode and CPU clock select block
`timescale 1ns/1ps
`default_nettype none
module test_clock_mode_and_cpu_clock_select;
  import clock_ctrl_pkg::*;

  logic clk_sys = 1'b0, srst = 1'b1, busWr = 1'b0, busBitOp = 1'b0, busRd = 1'b0;
  logic [15:0] busAddr = 16'h0000;
  logic [2:0]  busBitSel = 3'h0;
  logic [7:0]  busWrData = 8'h00, busRdData;
  logic hsOscStop = 1'b1, mainClkIsHs = 1'b0, stopRelease = 1'b0, oscStableDone = 1'b0;
  logic hsExtClkPin = 1'b0, subClkPin = 1'b0, extRun = 1'b0;
  logic [2:0] phase = 3'h0;
  pin_mode_e hsPinMode, subPinMode;
  logic hsCrystalEnable, hsExtClockEnable, subCrystalEnable, subExtClockEnable;
  logic gainHigh, cpuHold, cpuClkEn, instrEn, cpuOnSubclock;
  int fails = 0, check_count = 0;

  clock_mode_cpu_clock clock_mode_cpu_clock_i (.clk_sys(clk_sys), .srst(srst),
    .busAddr(busAddr), .busWr(busWr), .busBitOp(busBitOp), .busBitSel(busBitSel),
    .busWrData(busWrData), .busRd(busRd), .busRdData(busRdData), .hsOscStop(hsOscStop),
    .mainClkIsHs(mainClkIsHs), .stopRelease(stopRelease), .oscStableDone(oscStableDone),
    .hsExtClkPin(hsExtClkPin), .subClkPin(subClkPin), .hsPinMode(hsPinMode),
    .subPinMode(subPinMode), .hsCrystalEnable(hsCrystalEnable),
    .hsExtClockEnable(hsExtClockEnable), .subCrystalEnable(subCrystalEnable),
    .subExtClockEnable(subExtClockEnable), .gainHigh(gainHigh), .cpuHold(cpuHold),
    .cpuClkEn(cpuClkEn), .instrEn(instrEn), .cpuOnSubclock(cpuOnSubclock));

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  // Pin clocks: subclock period 8 cycles, external clock period 4 cycles when enabled
  always @(negedge clk_sys) begin
    phase <= phase + 3'h1;
    subClkPin <= phase[2];
    hsExtClkPin <= extRun & phase[1];
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic doReset();
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
  endtask

  // Byte or single-bit write, strobe held for exactly one edge; the free cycle
  // first keeps back-to-back calls from dropping and raising it in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bitOp,
                    input logic [2:0] sel);
    cyc(1);
    busAddr   = a;
    busWrData = d;
    busBitOp  = bitOp;
    busBitSel = sel;
    busWr     = 1'b1;
    cyc(1);
    busWr    = 1'b0;
    busBitOp = 1'b0;
  endtask

  task automatic rdCheck(input string name, input logic [15:0] a, input logic [7:0] exp);
    cyc(1);
    busAddr = a;
    busRd   = 1'b1;
    cyc(1);
    busRd = 1'b0;
    check(name, busRdData, exp);
  endtask

  // Counts CPU clock and instruction pulses over n cycles, aligned to a CPU clock pulse
  task automatic pulses(input int n, output int ce, output int ie);
    int k;
    k = 0; ce = 0; ie = 0;
    while (cpuClkEn !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    repeat (n) begin
      cyc(1);
      if (cpuClkEn === 1'b1) ce++;
      if (instrEn === 1'b1) ie++;
    end
  endtask

  // Length of a CPU clock withhold in cycles
  task automatic holdLen(output int n);
    int k;
    k = 0; n = 0;
    while (cpuHold !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    while (cpuHold === 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rdCheck("pinModeReset", ADDR_PIN_MODE, 8'h00);
    rdCheck("cpuClkReset", ADDR_CPU_CLK, 8'h01);
    rdCheck("unmappedRead", 16'hFFA0, 8'h00);
    check("hsModeReset", 32'(hsPinMode), 32'(PIN_PORT));
    check("gainReset", gainHigh, 1'b0);
    $display("Test reset values done");
  endtask

  task automatic t_div();
    int ce, ie;
    for (int d = 0; d <= 4; d++) begin
      wr(ADDR_CPU_CLK, 8'(d), 1'b0, 3'h0);
      cyc(40);
      pulses(8 << d, ce, ie);
      check("divPulses", ce, 8);
      check("instrPulses", ie, 4);
    end
    wr(ADDR_CPU_CLK, 8'h05, 1'b0, 3'h0);
    rdCheck("prohibitedDiv", ADDR_CPU_CLK, 8'h04);
    wr(ADDR_CPU_CLK, 8'h22, 1'b0, 3'h0);
    rdCheck("fixedBits", ADDR_CPU_CLK, 8'h02);
    wr(ADDR_CPU_CLK, 8'h10, 1'b0, 3'h0);
    cyc(60);
    check("onSubclock", cpuOnSubclock, 1'b1);
    rdCheck("subStatusRead", ADDR_CPU_CLK, 8'h30);
    pulses(64, ce, ie);
    check("subPulses", ce, 4);
    wr(ADDR_CPU_CLK, 8'h01, 1'b0, 3'h0);
    cyc(60);
    check("backOnMain", cpuOnSubclock, 1'b0);
    $display("Test CPU clock divider done");
  endtask

  task automatic t_pins();
    logic [7:0] v [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
    pin_mode_e m [4] = '{PIN_PORT, PIN_CRYSTAL, PIN_PORT, PIN_EXTCLK};
    // mode bits change only with the oscillator stopped
    hsOscStop = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PIN_MODE, v[i], 1'b0, 3'h0);
      cyc(2);
      check("hsMode", 32'(hsPinMode), 32'(m[i]));
      check("hsCrystalStopped", hsCrystalEnable, 1'b0);
      check("hsExtStopped", hsExtClockEnable, 1'b0);
    end
    wr(ADDR_PIN_MODE, 8'h0E, 1'b0, 3'h0);
    wr(ADDR_PIN_MODE, 8'h01, 1'b1, 3'h7);
    rdCheck("bitWriteTop", ADDR_PIN_MODE, 8'h80);
    wr(ADDR_PIN_MODE, 8'h00, 1'b1, 3'h7);
    wr(ADDR_PIN_MODE, 8'h01, 1'b1, 3'h6);
    rdCheck("bitWrite", ADDR_PIN_MODE, 8'h40);
    hsOscStop = 1'b0;
    cyc(2);
    check("hsCrystalRun", hsCrystalEnable, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PIN_MODE, 8'h40 | (v[i] >> 2), 1'b0, 3'h0);
      cyc(2);
      check("subMode", 32'(subPinMode), 32'(m[i]));
      check("subExtEn", subExtClockEnable, m[i] == PIN_EXTCLK);
    end
    wr(ADDR_PIN_MODE, 8'h60, 1'b0, 3'h0);
    wr(ADDR_CPU_CLK, 8'h01, 1'b1, 3'h6);
    cyc(2);
    check("subStartBit", 32'(subPinMode), 32'(PIN_CRYSTAL));
    check("subCrystalEn", subCrystalEnable, 1'b1);
    wr(ADDR_CPU_CLK, 8'h00, 1'b1, 3'h6);
    wr(ADDR_PIN_MODE, 8'h40, 1'b0, 3'h0);
    $display("Test pin modes done");
  endtask

  task automatic t_gain();
    int n;
    mainClkIsHs = 1'b1;
    // gain raised as for a high-speed clock above 10 MHz
    wr(ADDR_PIN_MODE, 8'h01, 1'b1, 3'h0);
    holdLen(n);
    check("crystalHold", n, WITHHOLD_CYCLES);
    wr(ADDR_PIN_MODE, 8'h00, 1'b1, 3'h0);
    cyc(2);
    check("gainLocked", gainHigh, 1'b1);
    check("noSecondHold", cpuHold, 1'b0);
    $display("Test gain withhold done");
  endtask

  task automatic t_ext();
    int n;
    doReset();
    hsOscStop = 1'b1;
    wr(ADDR_PIN_MODE, 8'hC0, 1'b0, 3'h0);
    hsOscStop = 1'b0;
    extRun = 1'b1;
    mainClkIsHs = 1'b1;
    cyc(10);
    check("hsExtRun", hsExtClockEnable, 1'b1);
    wr(ADDR_PIN_MODE, 8'h01, 1'b1, 3'h0);
    holdLen(n);
    check("extHold", n >= 632 && n <= 648, 1'b1);
    mainClkIsHs = 1'b0;
    stopRelease = 1'b1;
    cyc(1);
    stopRelease = 1'b0;
    holdLen(n);
    check("stopTimedHold", n, WITHHOLD_CYCLES);
    hsOscStop = 1'b1;
    wr(ADDR_PIN_MODE, 8'h41, 1'b0, 3'h0);
    mainClkIsHs = 1'b1;
    stopRelease = 1'b1;
    cyc(1);
    stopRelease = 1'b0;
    cyc(50);
    check("stabHoldOn", cpuHold, 1'b1);
    oscStableDone = 1'b1;
    cyc(4);
    check("stabHoldOff", cpuHold, 1'b0);
    $display("Test external and stop withhold done");
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(1);
    doReset();
    t_reset();
    t_div();
    t_pins();
    t_gain();
    t_ext();
    test_done();
  end

  // Watchdog: tests take about 2500 cycles, allow twenty times that
  initial begin
    #500000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
